// >>> dac_consts.vh
/*
  Constants for the accessory aspect controller: register offsets, field
  positions, reset values and timing figures.
  Assumes a 100 MHz system clock and a 12-bit Avalon-MM byte address.
*/
`ifndef DAC_CONSTS_VH
`define DAC_CONSTS_VH

// clock and timing, in nanoseconds
`define DAC_CLK_NS         32'h0000_000A
`define DAC_RET_BASE_NS    32'h03B9_ACA0
`define DAC_BLINK_NS       32'h0EE6_B280

// register byte offsets
`define DAC_REG_CTRL       12'h000
`define DAC_REG_BASIC      12'h004
`define DAC_REG_EXT        12'h008
`define DAC_REG_MODXADDR   12'h00C
`define DAC_REG_GROUPS     12'h010
`define DAC_REG_HWCFG      12'h014
`define DAC_REG_VERSION    12'h018
`define DAC_REG_ID0        12'h01C
`define DAC_REG_ID1        12'h020
`define DAC_REG_ID2        12'h024
`define DAC_REG_STATUS     12'h028
`define DAC_REG_OUT        12'h02C

// table regions: device slots at 0x400, aspect patterns at 0x800
`define DAC_DEV_REGION     5'h08
`define DAC_PAT_BIT        11

// control fields
`define DAC_CTRL_INV       0
`define DAC_CTRL_ZERO      1
`define DAC_CTRL_RET       3:2
`define DAC_CTRL_BLOFF     4
`define DAC_CTRL_ERASE     8

// address range fields
`define DAC_ADDR_FIRST     10:0
`define DAC_ADDR_CNT       21:16

// device slot fields
`define DAC_DEV_PIN        4:0
`define DAC_DEV_NUM        8:5
`define DAC_DEV_TWELVE     9

// factory defaults
`define DAC_RST_FIRST      11'h001
`define DAC_RST_BCNT       6'h08
`define DAC_RST_XCNT       6'h00
`define DAC_RST_RET        2'h2
`define DAC_RST_MODXADDR   16'h0001
`define DAC_RST_DRV        2'h0

// limits and encodings
`define DAC_ASP_FEW        5'h04
`define DAC_ASP_MANY       5'h0C
`define DAC_MAX_DEC        12'h008
`define DAC_XADDR_MAX      12'h020
`define DAC_DRV_SINK       2'h1
`define DAC_DRV_SRC        2'h2
`define DAC_DRV_BOTH       2'h3
`define DAC_ERASE_LAST     9'h1FF

`endif

// >>> dac_out_group.v
/*
  One group of eight outputs: maps logical pin levels onto the sink and
  source driver lines according to the fitted driver type.
  Assumes logical levels come from logic on the same clock.
*/
`timescale 1ns/1ns
`include "dac_consts.vh"

module dac_out_group #(
  parameter W = 8
) (
  // clock and reset
  input  wire         sys_clk_i,
  input  wire         rst_i,
  // logical levels and driver setting
  input  wire [W-1:0] lvl_i,
  input  wire [1:0]   drv_cfg_i,
  // driver lines
  output reg  [W-1:0] sink_o,
  output reg  [W-1:0] src_o
);

  // pairwise interchange of adjacent lines
  wire [W-1:0] swp;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 2) begin : g_swp
      assign swp[i]   = lvl_i[i+1];
      assign swp[i+1] = lvl_i[i];
    end
  endgenerate

  // source line j feeds half swp(j): swapping again lands on the right half
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sink_o <= {W{1'b0}};
      src_o  <= {W{1'b0}};
    end else begin
      case (drv_cfg_i)
        `DAC_DRV_SINK: begin
          sink_o <= lvl_i;
          src_o  <= {W{1'b0}};
        end
        `DAC_DRV_SRC: begin
          sink_o <= {W{1'b0}};
          src_o  <= swp;
        end
        `DAC_DRV_BOTH: begin
          sink_o <= ~lvl_i;
          src_o  <= swp;
        end
        // resistor array: plain levels on the sink lines
        default: begin
          sink_o <= lvl_i;
          src_o  <= {W{1'b0}};
        end
      endcase
    end
  end

endmodule // dac_out_group

// >>> dac_ctrl.v
/*
  Accessory aspect controller: decodes basic and extended accessory packets,
  suppresses repeats, selects device aspects and drives grouped outputs.
  Configuration over an Avalon-MM slave with waitrequest.
  Assumes packets arrive already decoded, as one-cycle strobes on sys_clk_i.
*/
`timescale 1ns/1ns
`include "dac_consts.vh"

// Functional notes
// - basic state 0/1 selects aspect 0/1
// - inversion option swaps mapping, whole module
// - consecutive basic decoders from first, four ports each
// - default numbering starts at decoder one
// - zero option numbers basic and extended from zero
// - extended: one address per device, max 32
// - basic and extended packets freely interleaved
// - identical packet within retention acts once
// - module extended address always held; erase resets it to 1 here
// - sixteen-bit group membership mask
// - twelve-character identity text, no effect
// - driver setting per eight outputs, four choices
// - source driver: adjacent outputs swapped
// - sink and source never on together
// - erase restores factory configuration
// - device has 4 or 12 aspects
// - device identified by its control pin
// - version request answers firmware version
// - setting disables green indicator blinking
module dac_ctrl #(
  parameter        NUM_OUT      = 32,
  parameter [31:0] RET_BASE_CYC = `DAC_RET_BASE_NS / `DAC_CLK_NS,
  parameter [31:0] BLINK_CYC    = `DAC_BLINK_NS / `DAC_CLK_NS,
  parameter [31:0] FW_VERSION   = 32'h0300_0001
) (
  // clock and reset
  input  wire               sys_clk_i,
  input  wire               rst_i,
  // avalon-mm slave
  input  wire [11:0]        avs_address_i,
  input  wire               avs_read_i,
  input  wire               avs_write_i,
  input  wire [31:0]        avs_writedata_i,
  input  wire [3:0]         avs_byteenable_i,
  output reg  [31:0]        avs_readdata_o,
  output reg                avs_waitrequest_o,
  // decoded accessory packets
  input  wire               pkt_valid_i,
  input  wire               pkt_ext_i,
  input  wire [10:0]        pkt_addr_i,
  input  wire [1:0]         pkt_port_i,
  input  wire               pkt_state_i,
  input  wire [4:0]         pkt_aspect_i,
  // output drivers and indicator
  output wire [NUM_OUT-1:0] sink_o,
  output wire [NUM_OUT-1:0] src_o,
  output reg                led_green_o
);

  localparam NG = NUM_OUT / 8;

  // configuration registers
  reg               inv;
  reg               zero_en;
  reg  [1:0]        ret_sel;
  reg               blink_off;
  reg  [10:0]       b_first;
  reg  [5:0]        b_cnt;
  reg  [10:0]       x_first;
  reg  [5:0]        x_cnt;
  reg  [15:0]       mod_xaddr;
  reg  [15:0]       grp_mask;
  reg  [2*NG-1:0]   hw_cfg;
  reg  [31:0]       id0;
  reg  [31:0]       id1;
  reg  [31:0]       id2;
  reg               erase_busy;
  reg  [8:0]        erase_idx;

  // device slots and aspect patterns
  reg  [9:0]        dev_mem [0:31];
  reg  [15:0]       pat_mem [0:511];

  // packet path state
  reg  [16:0]       last_key;
  reg  [26:0]       ret_cnt;
  reg               ap_vld;
  reg  [4:0]        ap_slot;
  reg  [4:0]        ap_asp;
  reg  [4:0]        st_slot;
  reg  [4:0]        st_asp;
  reg  [NUM_OUT-1:0] lvl;
  reg  [27:0]       blink_cnt;

  // bus helpers
  reg  [31:0]       rd_word;
  reg               pat_we;
  reg               dev_we;
  reg  [8:0]        mem_idx;
  reg  [15:0]       mem_wd;
  wire              bus_go = (avs_read_i | avs_write_i) & avs_waitrequest_o & ~erase_busy;
  wire [31:0]       wd;

  // byte-lane merge of write data onto the current value
  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer      k;
    begin
      be_merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (be[k])
          be_merge[k*8 +: 8] = nw[k*8 +: 8];
    end
  endfunction

  assign wd = be_merge(rd_word, avs_writedata_i, avs_byteenable_i);

  // factory configuration, shared by reset and erase
  task set_defaults;
    begin
      inv       <= 1'b0;
      zero_en   <= 1'b0;
      ret_sel   <= `DAC_RST_RET;
      blink_off <= 1'b0;
      b_first   <= `DAC_RST_FIRST;
      b_cnt     <= `DAC_RST_BCNT;
      x_first   <= `DAC_RST_FIRST;
      x_cnt     <= `DAC_RST_XCNT;
      mod_xaddr <= `DAC_RST_MODXADDR;
      grp_mask  <= 16'h0000;
      hw_cfg    <= {NG{`DAC_RST_DRV}};
      id0       <= 32'h0000_0000;
      id1       <= 32'h0000_0000;
      id2       <= 32'h0000_0000;
    end
  endtask

  // register read mux; unmapped offsets read zero
  always @* begin
    rd_word = 32'h0000_0000;
    if (avs_address_i[`DAC_PAT_BIT]) begin
      rd_word[15:0] = pat_mem[avs_address_i[10:2]];
    end else if (avs_address_i[11:7] == `DAC_DEV_REGION) begin
      rd_word[9:0] = dev_mem[avs_address_i[6:2]];
    end else begin
      case (avs_address_i)
        `DAC_REG_CTRL: begin
          rd_word[`DAC_CTRL_INV]   = inv;
          rd_word[`DAC_CTRL_ZERO]  = zero_en;
          rd_word[`DAC_CTRL_RET]   = ret_sel;
          rd_word[`DAC_CTRL_BLOFF] = blink_off;
          rd_word[`DAC_CTRL_ERASE] = erase_busy;
        end
        `DAC_REG_BASIC: begin
          rd_word[`DAC_ADDR_FIRST] = b_first;
          rd_word[`DAC_ADDR_CNT]   = b_cnt;
        end
        `DAC_REG_EXT: begin
          rd_word[`DAC_ADDR_FIRST] = x_first;
          rd_word[`DAC_ADDR_CNT]   = x_cnt;
        end
        `DAC_REG_MODXADDR: rd_word[15:0] = mod_xaddr;
        `DAC_REG_GROUPS:   rd_word[15:0] = grp_mask;
        `DAC_REG_HWCFG:    rd_word[2*NG-1:0] = hw_cfg;
        `DAC_REG_VERSION:  rd_word = FW_VERSION;
        `DAC_REG_ID0:      rd_word = id0;
        `DAC_REG_ID1:      rd_word = id1;
        `DAC_REG_ID2:      rd_word = id2;
        `DAC_REG_STATUS:   rd_word = {15'h0000, (ret_cnt != 27'h0000000), 3'h0, st_slot, 3'h0, st_asp};
        `DAC_REG_OUT:      rd_word[NUM_OUT-1:0] = lvl;
        default:           rd_word = 32'h0000_0000;
      endcase
    end
  end

  // table write strobes; erase sweeps both tables to zero
  always @* begin
    pat_we  = 1'b0;
    dev_we  = 1'b0;
    mem_idx = avs_address_i[10:2];
    mem_wd  = avs_writedata_i[15:0];
    if (erase_busy) begin
      pat_we  = 1'b1;
      dev_we  = (erase_idx[8:5] == 4'h0);
      mem_idx = erase_idx;
      mem_wd  = 16'h0000;
    end else if (bus_go & avs_write_i) begin
      pat_we  = avs_address_i[`DAC_PAT_BIT];
      dev_we  = (avs_address_i[11:7] == `DAC_DEV_REGION);
      mem_idx = {4'h0, avs_address_i[6:2]};
      if (avs_address_i[`DAC_PAT_BIT])
        mem_idx = avs_address_i[10:2];
    end
  end

  // table storage, no reset: erase clears it instead
  always @(posedge sys_clk_i) begin
    if (pat_we)
      pat_mem[mem_idx] <= mem_wd;
    if (dev_we)
      dev_mem[mem_idx[4:0]] <= mem_wd[9:0];
  end

  // bus slave and configuration registers; one wait cycle per access when no erase runs, else held until the erase ends
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      set_defaults;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
      erase_busy        <= 1'b0;
      erase_idx         <= 9'h000;
    end else begin
      avs_waitrequest_o <= 1'b1;
      if (erase_busy) begin
        erase_idx <= erase_idx + 9'h001;
        if (erase_idx == `DAC_ERASE_LAST)
          erase_busy <= 1'b0;
      end else if (bus_go) begin
        avs_waitrequest_o <= 1'b0;
        avs_readdata_o    <= avs_read_i ? rd_word : 32'h0000_0000;
        if (avs_write_i) begin
          case (avs_address_i)
            `DAC_REG_CTRL: begin
              inv       <= wd[`DAC_CTRL_INV];
              zero_en   <= wd[`DAC_CTRL_ZERO];
              ret_sel   <= wd[`DAC_CTRL_RET];
              blink_off <= wd[`DAC_CTRL_BLOFF];
              if (wd[`DAC_CTRL_ERASE]) begin
                set_defaults;
                erase_busy <= 1'b1;
                erase_idx  <= 9'h000;
              end
            end
            `DAC_REG_BASIC: begin
              b_first <= wd[`DAC_ADDR_FIRST];
              b_cnt   <= wd[`DAC_ADDR_CNT];
            end
            `DAC_REG_EXT: begin
              x_first <= wd[`DAC_ADDR_FIRST];
              x_cnt   <= wd[`DAC_ADDR_CNT];
            end
            `DAC_REG_MODXADDR: mod_xaddr <= wd[15:0];
            `DAC_REG_GROUPS:   grp_mask <= wd[15:0];
            `DAC_REG_HWCFG:    hw_cfg <= wd[2*NG-1:0];
            `DAC_REG_ID0:      id0 <= wd;
            `DAC_REG_ID1:      id1 <= wd;
            `DAC_REG_ID2:      id2 <= wd;
            default: ;
          endcase
        end
      end
    end
  end

  // user number is wire address plus one unless zero numbering
  wire [11:0] dec_num = {1'b0, pkt_addr_i} + {11'h000, ~zero_en};
  wire [11:0] b_off   = dec_num - {1'b0, b_first};
  wire [11:0] x_off   = dec_num - {1'b0, x_first};

  // basic window, four ports per decoder
  wire        b_hit = ~pkt_ext_i & (dec_num >= {1'b0, b_first}) &
                      (b_off < {6'h00, b_cnt}) & (b_off < `DAC_MAX_DEC);
  // extended window, one slot per address
  wire        x_hit = pkt_ext_i & (dec_num >= {1'b0, x_first}) &
                      (x_off < {6'h00, x_cnt}) & (x_off < `DAC_XADDR_MAX);

  // slot number is the control pin's device slot
  wire [4:0]  slot_a = pkt_ext_i ? x_off[4:0] : {b_off[2:0], pkt_port_i};
  // basic state picks aspect 0 or 1
  wire [4:0]  asp_a  = pkt_ext_i ? pkt_aspect_i : {4'h0, pkt_state_i ^ inv};

  // whole packet identity for repeat detection
  wire [16:0] key    = {pkt_ext_i, pkt_addr_i,
                        (pkt_ext_i ? pkt_aspect_i : {2'h0, pkt_port_i, pkt_state_i})};
  wire        dup    = (ret_cnt != 27'h0000000) & (key == last_key);
  // either kind on the same strobe
  wire        accept = pkt_valid_i & ~erase_busy & (b_hit | x_hit) & ~dup;

  // retention period: base figure doubled per select step
  wire [31:0] ret_full   = RET_BASE_CYC << ret_sel;
  wire [26:0] ret_period = ret_full[26:0];

  // aspect application from the slot and its pattern
  wire [9:0]  dcfg    = dev_mem[ap_slot];
  wire [15:0] pat     = pat_mem[{ap_slot, ap_asp[3:0]}];
  wire [4:0]  asp_lim = dcfg[`DAC_DEV_TWELVE] ? `DAC_ASP_MANY : `DAC_ASP_FEW;
  wire [15:0] msk16   = 16'hFFFF >> (4'hF - dcfg[`DAC_DEV_NUM]);
  wire [NUM_OUT-1:0] put_msk = {{(NUM_OUT-16){1'b0}}, msk16} << dcfg[`DAC_DEV_PIN];
  wire [NUM_OUT-1:0] put_val = {{(NUM_OUT-16){1'b0}}, pat & msk16} << dcfg[`DAC_DEV_PIN];

  // packet acceptance, retention timer and aspect pipeline
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_key <= 17'h00000;
      ret_cnt  <= 27'h0000000;
      ap_vld   <= 1'b0;
      ap_slot  <= 5'h00;
      ap_asp   <= 5'h00;
      st_slot  <= 5'h00;
      st_asp   <= 5'h00;
      lvl      <= {NUM_OUT{1'b0}};
    end else begin
      ap_vld <= 1'b0;
      if (ret_cnt != 27'h0000000)
        ret_cnt <= ret_cnt - 27'h0000001;
      // misses leave key, timer and outputs alone
      if (accept) begin
        last_key <= key;
        ret_cnt  <= ret_period;
        ap_vld   <= 1'b1;
        ap_slot  <= slot_a;
        ap_asp   <= asp_a;
      end
      if (ap_vld & (ap_asp < asp_lim)) begin
        lvl     <= (lvl & ~put_msk) | put_val;
        st_slot <= ap_slot;
        st_asp  <= ap_asp;
      end
    end
  end

  // green indicator: blinks, or steady on when disabled
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      blink_cnt   <= 28'h0000000;
      led_green_o <= 1'b0;
    end else if (blink_off) begin
      blink_cnt   <= 28'h0000000;
      led_green_o <= 1'b1;
    end else if (blink_cnt >= BLINK_CYC[27:0] - 28'h0000001) begin
      blink_cnt   <= 28'h0000000;
      led_green_o <= ~led_green_o;
    end else begin
      blink_cnt <= blink_cnt + 28'h0000001;
    end
  end

  // one driver mapper per group of eight outputs
  genvar g;
  generate
    for (g = 0; g < NG; g = g + 1) begin : g_grp
      dac_out_group #(
        .W (8)
      ) u_grp (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .lvl_i     (lvl[g*8 +: 8]),
        .drv_cfg_i (hw_cfg[g*2 +: 2]),
        .sink_o    (sink_o[g*8 +: 8]),
        .src_o     (src_o[g*8 +: 8])
      );
    end
  endgenerate

endmodule // dac_ctrl

// >>> dac_ctrl_properties.sv
/*
  Port checker for the accessory aspect controller, bound to its top.
  Assumes one clock and rst_i asynchronous, active high.
*/
`timescale 1ns/1ns
`include "dac_consts.vh"

module dac_ctrl_props #(
  parameter        NUM_OUT    = 32,
  parameter [31:0] BLINK_CYC  = 8,
  parameter [31:0] FW_VERSION = 32'h0300_0001
) (
  // clock and reset
  input wire               sys_clk_i,
  input wire               rst_i,
  // register bus
  input wire [11:0]        avs_address_i,
  input wire               avs_read_i,
  input wire               avs_write_i,
  input wire [31:0]        avs_readdata_o,
  input wire               avs_waitrequest_o,
  // packets and outputs
  input wire               pkt_valid_i,
  input wire [NUM_OUT-1:0] sink_o,
  input wire [NUM_OUT-1:0] src_o,
  input wire               led_green_o
);
  // source lines seen from the half they feed
  wire [NUM_OUT-1:0] src_sw;
  genvar j;
  for (j = 0; j < NUM_OUT; j = j + 1) begin : g_sw
    assign src_sw[j] = src_o[j ^ 1];
  end
  // cycles since the indicator last moved
  reg [31:0] led_cnt;
  reg        led_q;
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      led_cnt <= 32'h0;
      led_q   <= 1'b0;
    end else begin
      led_q   <= led_green_o;
      led_cnt <= (led_green_o != led_q) ? 32'h0 : led_cnt + 32'h1;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  wait_cause_a: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i) || $past(avs_write_i))
    else $error("answer without request");
  bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |-> ##[1:600] !avs_waitrequest_o)
    else $error("bus request never answered");
  write_zero_a: assert property ($fell(avs_waitrequest_o) && $past(avs_write_i) |-> avs_readdata_o == 32'h0)
    else $error("read data not zero after write");
  read_hold_a: assert property (!avs_read_i && !avs_write_i |=> $stable(avs_readdata_o))
    else $error("read data moved without access");
  version_read_a: assert property ($fell(avs_waitrequest_o) && $past(avs_read_i) &&
    $past(avs_address_i) == `DAC_REG_VERSION |-> avs_readdata_o == FW_VERSION)
    else $error("version read wrong");
  unmapped_zero_a: assert property ($fell(avs_waitrequest_o) && $past(avs_read_i) &&
    $past(avs_address_i) inside {[12'h030:12'h3FF]} |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  no_short_a: assert property ((sink_o & src_sw) == {NUM_OUT{1'b0}})
    else $error("sink and source of one half both on");
  out_cause_a: assert property (!$stable(sink_o) || !$stable(src_o) |-> $past(pkt_valid_i, 3) ||
    $past(avs_write_i, 2) || $past(avs_write_i, 3))
    else $error("driver lines moved without cause");
  led_period_a: assert property ($fell(led_green_o) |-> led_cnt == BLINK_CYC - 32'h1)
    else $error("indicator blink period wrong");
endmodule // dac_ctrl_props

bind dac_ctrl dac_ctrl_props #(.NUM_OUT(NUM_OUT), .BLINK_CYC(BLINK_CYC), .FW_VERSION(FW_VERSION)) i_props (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .pkt_valid_i(pkt_valid_i), .sink_o(sink_o), .src_o(src_o), .led_green_o(led_green_o));

// >>> dac_station.sv
/*
  Command station model: issues decoded accessory packets as strobes.
  Assumes the controller samples on the rising clock edge.
*/
`timescale 1ns/1ns

module dac_station (
  // clock
  input  wire         sys_clk_i,
  // decoded packet
  output logic        pkt_valid_o  = 1'b0,
  output logic        pkt_ext_o    = 1'b0,
  output logic [10:0] pkt_addr_o   = 11'h000,
  output logic [1:0]  pkt_port_o   = 2'h0,
  output logic        pkt_state_o  = 1'b0,
  output logic [4:0]  pkt_aspect_o = 5'h00
);
  // fields inverted after the strobe so stale values are never trusted
  task send(input logic e, input logic [10:0] a, input logic [1:0] p, input logic s, input logic [4:0] x);
    @(posedge sys_clk_i);
    pkt_valid_o  <= 1'b1;
    pkt_ext_o    <= e;
    pkt_addr_o   <= a;
    pkt_port_o   <= p;
    pkt_state_o  <= s;
    pkt_aspect_o <= x;
    @(posedge sys_clk_i);
    pkt_valid_o  <= 1'b0;
    pkt_ext_o    <= ~e;
    pkt_addr_o   <= ~a;
    pkt_port_o   <= ~p;
    pkt_state_o  <= ~s;
    pkt_aspect_o <= ~x;
  endtask
endmodule // dac_station

// >>> dac_ctrl_bench.sv
/*
  Self-checking bench for the accessory aspect controller.
  Assumes short retention and blink counts set through parameters.
*/
`timescale 1ns/1ns
`include "dac_consts.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module dac_ctrl_bench;
  logic        sys_clk_i       = 1'b0;
  logic        rst_i           = 1'b1;
  logic [11:0] avs_address_i   = 12'h000;
  logic        avs_read_i      = 1'b0;
  logic        avs_write_i     = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  wire  [31:0] avs_readdata_o;
  wire         avs_waitrequest_o;
  wire         pv, pe, ps, led_green_o;
  wire  [10:0] pa;
  wire  [1:0]  pp;
  wire  [4:0]  px;
  wire  [31:0] sink_o, src_o;
  int          mismatches = 0;
  int          compares   = 0;
  logic [31:0] expq[$];
  logic [31:0] ev, r;
  logic [15:0] lfsr = 16'h9207;
  logic [11:0] ra[5] = '{`DAC_REG_MODXADDR, `DAC_REG_GROUPS, `DAC_REG_ID0, `DAC_REG_ID1, `DAC_REG_ID2};
  logic [31:0] rm[5] = '{32'h0000_FFFF, 32'h0000_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
  logic [7:0]  se[4] = '{8'h0B, 8'h0B, 8'h00, 8'hF4};
  logic [7:0]  sr[4] = '{8'h00, 8'h00, 8'h07, 8'h07};

  dac_ctrl #(.RET_BASE_CYC(32'd20), .BLINK_CYC(32'd8)) i_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .pkt_valid_i(pv),
    .pkt_ext_i(pe), .pkt_addr_i(pa), .pkt_port_i(pp), .pkt_state_i(ps), .pkt_aspect_i(px),
    .sink_o(sink_o), .src_o(src_o), .led_green_o(led_green_o));
  dac_station i_station (
    .sys_clk_i(sys_clk_i), .pkt_valid_o(pv), .pkt_ext_o(pe), .pkt_addr_o(pa), .pkt_port_o(pp),
    .pkt_state_o(ps), .pkt_aspect_o(px));

  // 100 MHz clock
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    rnd  = {lfsr, ~lfsr};
  endfunction

  // one access, held until waitrequest is sampled low
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    avs_read_i      <= !w;
    avs_write_i     <= w;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 1000);
    if (n >= 1000) begin
      mismatches++;
      $display("[ERR] %0t bus hang", $time);
    end
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // send a packet, then note the expected output levels
  task pk(input logic e, input logic [10:0] a, input logic [1:0] p, input logic s, input logic [4:0] x,
          input logic [31:0] o);
    i_station.send(e, a, p, s, x);
    rd(`DAC_REG_OUT, o);
  endtask

  // read answers checked against the oldest note
  always @(posedge sys_clk_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0 && expq.size() > 0) begin
      ev = expq.pop_front();
      `CHK(avs_readdata_o, ev)
    end
  end

  task complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #400000;
    mismatches++;
    complete_run();
  end

  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    wr(`DAC_REG_CTRL, 32'h0000_0100);
    rd(`DAC_REG_CTRL, 32'h0000_0008);
    rd(`DAC_REG_BASIC, 32'h0008_0001);
    rd(`DAC_REG_EXT, 32'h0000_0001);
    rd(`DAC_REG_VERSION, 32'h0300_0001);
    rd(12'h030, 32'h0);
    for (int i = 0; i < 5; i++) begin
      r = rnd();
      wr(ra[i], r);
      rd(ra[i], r & rm[i]);
    end
    // device slots and aspect patterns
    wr(12'h404, 32'h0);
    wr(12'h840, 32'h1);
    wr(12'h844, 32'h0);
    wr(12'h414, 32'h3);
    wr(12'h944, 32'h1);
    wr(12'h47C, 32'h1);
    wr(12'hFC0, 32'h1);
    wr(12'h400, 32'h208);
    wr(12'h82C, 32'h1);
    pk(0, 11'h0, 2'h1, 0, 5'h0, 32'h1);
    pk(0, 11'h0, 2'h1, 1, 5'h0, 32'h0);
    pk(0, 11'h0, 2'h1, 0, 5'h0, 32'h1);
    wr(12'h840, 32'h0);
    pk(0, 11'h0, 2'h1, 0, 5'h0, 32'h1);
    repeat (200) @(posedge sys_clk_i);
    pk(0, 11'h0, 2'h1, 0, 5'h0, 32'h0);
    wr(12'h840, 32'h1);
    wr(`DAC_REG_CTRL, 32'h9);
    pk(0, 11'h0, 2'h1, 1, 5'h0, 32'h1);
    wr(`DAC_REG_CTRL, 32'h8);
    pk(0, 11'h1, 2'h1, 1, 5'h0, 32'h9);
    pk(0, 11'h7, 2'h3, 0, 5'h0, 32'hB);
    pk(0, 11'h8, 2'h0, 0, 5'h0, 32'hB);
    pk(1, 11'h0, 2'h0, 0, 5'h0B, 32'hB);
    wr(`DAC_REG_EXT, 32'h0001_0001);
    pk(1, 11'h0, 2'h0, 0, 5'h0C, 32'hB);
    i_station.send(1, 11'h0, 2'h0, 0, 5'h0B);
    pk(0, 11'h0, 2'h1, 1, 5'h0, 32'h10A);
    wr(`DAC_REG_CTRL, 32'hA);
    pk(0, 11'h1, 2'h1, 0, 5'h0, 32'h10B);
    // shortest retention: a repeat after it runs out acts again
    wr(`DAC_REG_CTRL, 32'h2);
    pk(0, 11'h1, 2'h1, 1, 5'h0, 32'h10A);
    wr(12'h844, 32'h1);
    repeat (20) @(posedge sys_clk_i);
    pk(0, 11'h1, 2'h1, 1, 5'h0, 32'h10B);
    rd(`DAC_REG_STATUS, 32'h0001_0101);
    for (int m = 0; m < 4; m++) begin
      wr(`DAC_REG_HWCFG, m);
      repeat (3) @(posedge sys_clk_i);
      `CHK(sink_o[7:0], se[m])
      `CHK(src_o[7:0], sr[m])
    end
    rd(`DAC_REG_HWCFG, 32'h3);
    // mid-run reset: configuration back to defaults, outputs cleared
    rst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(`DAC_REG_CTRL, 32'h0000_0008);
    rd(`DAC_REG_OUT, 32'h0);
    wr(`DAC_REG_CTRL, 32'h1A);
    repeat (3) @(posedge sys_clk_i);
    `CHK(led_green_o, 1'b1)
    repeat (20) @(posedge sys_clk_i);
    `CHK(led_green_o, 1'b1)
    complete_run();
  end
endmodule // dac_ctrl_bench
